// file: rtl/keypad_pkg.sv
package keypad_pkg;

  // ----------------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFS_KEY      = 8'h00;
  localparam logic [7:0]  OFS_SELECT   = 8'h04;
  localparam logic [7:0]  OFS_FLAGS    = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0c;
  localparam logic [7:0]  OFS_ALARM    = 8'h10;
  localparam logic [7:0]  OFS_DISPLAY  = 8'h14;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------------
  // Key word fields: function code, value-present flag, signed value
  // ----------------------------------------------------------------------
  localparam int unsigned KEY_FN_LSB   = 0;
  localparam int unsigned KEY_HAS_BIT  = 8;
  localparam int unsigned KEY_VAL_LSB  = 16;

  // Function codes.
  localparam logic [3:0] FN_LINE_PICK  = 4'h0;
  localparam logic [3:0] FN_SITE       = 4'h1;
  localparam logic [3:0] FN_LATCH      = 4'h2;
  localparam logic [3:0] FN_INVERT     = 4'h3;
  localparam logic [3:0] FN_RISE_ALARM = 4'h4;
  localparam logic [3:0] FN_FALL_ALARM = 4'h5;
  localparam logic [3:0] FN_RELEASE    = 4'h6;
  localparam logic [3:0] FN_CAL_LINEAR = 4'h7;
  localparam logic [3:0] FN_CAL_SQUARE = 4'h8;
  localparam logic [3:0] FN_FLOOR      = 4'h9;
  localparam logic [3:0] FN_CEILING    = 4'ha;
  localparam logic [3:0] FN_THRESH_TGL = 4'hb;

  // Calibration modes.
  localparam logic [1:0] CAL_NONE      = 2'h0;
  localparam logic [1:0] CAL_LINEAR    = 2'h1;
  localparam logic [1:0] CAL_SQUARE    = 2'h2;
  localparam logic [1:0] CAL_PRODUCT   = 2'h3;

  // ----------------------------------------------------------------------
  // Channels, site, levels and timing
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_CHAN     = 32;
  localparam logic [5:0]  CHAN_FIRST   = 6'h01;
  localparam logic [5:0]  CHAN_LAST    = 6'h20;
  localparam int unsigned LEVEL_W      = 16;
  localparam logic [15:0] MIN_CAL_MV   = 16'h0100;
  localparam logic [7:0]  FACTORY_SITE = 8'h01;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned HOLD_MS      = 2000;
  localparam int unsigned HOLD_CYCLES  = HOLD_MS * (CLK_HZ / 1000);

endpackage

// file: rtl/keypad_function_key_handler.sv
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
// How it works
// - A function key ends a sequence and its effect applies at once.
// - Value then line pick selects that channel, shown on the channel display.
// - Line pick without value advances the channel, wrapping 32 to 1.
// - Value then site key replaces the site number used for answering.
// - Loss of memory restores the factory site number.
// - Latch, invert, rise and fall keys toggle the selected channel attribute.
// - Inverted channels complement the input before display and processing.
// - Latched channels hold ON after a rising edge, ignoring later edges.
// - Release of held inputs forces latched channels OFF until the next rise.
// - Alarms come from the conditioned value, after inversion and latching.
// - Fall alarm attribute raises an alarm on a conditioned falling edge.
// - Rise alarm attribute raises an alarm on each conditioned rising edge.
// - A value before a toggle or release key is an error, nothing changes.
// - Linear calibration scales display by present over calibration level.
// - Square calibration scales display by the square of that level ratio.
// - Negative square calibration scales by the product of two prior channels.
// - Calibration below 256 mV is refused with the error indication.
// - Value then limit key stores the limit; zero means no limit.
// - With checking on, exceeding a limit raises the high or low alarm.
// - A limit key without value shows the stored limit for two seconds.
// - The threshold toggle switches global checking and drives its indicator.
// - Any meaningless sequence shows the error indication for two seconds.
module keypad_function_key_handler
#(
  parameter int unsigned HOLD_CYCLES  = keypad_pkg::HOLD_CYCLES,
  parameter logic [7:0]  FACTORY_SITE = keypad_pkg::FACTORY_SITE
)
(
  input  wire logic                                     aclk,
  input  wire logic                                     aresetn,
  input  wire logic                                     ce,
  input  wire logic [keypad_pkg::ADDR_W-1:0]            s_axi_awaddr,
  input  wire logic                                     s_axi_awvalid,
  output logic                                          s_axi_awready,
  input  wire logic [31:0]                              s_axi_wdata,
  input  wire logic [3:0]                               s_axi_wstrb,
  input  wire logic                                     s_axi_wvalid,
  output logic                                          s_axi_wready,
  output logic [1:0]                                    s_axi_bresp,
  output logic                                          s_axi_bvalid,
  input  wire logic                                     s_axi_bready,
  input  wire logic [keypad_pkg::ADDR_W-1:0]            s_axi_araddr,
  input  wire logic                                     s_axi_arvalid,
  output logic                                          s_axi_arready,
  output logic [31:0]                                   s_axi_rdata,
  output logic [1:0]                                    s_axi_rresp,
  output logic                                          s_axi_rvalid,
  input  wire logic                                     s_axi_rready,
  input  wire logic [31:0]                              status_in,
  input  wire logic [keypad_pkg::NUM_CHAN*keypad_pkg::LEVEL_W-1:0] tele_levels,
  input  wire logic [7:0]                               site_query,
  output logic                                          site_match,
  output logic [5:0]                                    chan_display,
  output logic [31:0]                                   status_leds,
  output logic [3:0]                                    attr_leds,
  output logic                                          limits_led,
  output logic                                          hi_alarm,
  output logic                                          lo_alarm,
  output logic                                          error_show,
  output logic [31:0]                                   display_value
);
  import keypad_pkg::*;

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (HOLD_CYCLES == 0)
  begin : g_bad_hold
    $error("HOLD_CYCLES must be at least one");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [5:0]        chan;
    logic [7:0]        site;
    logic [31:0]       inv_mask;
    logic [31:0]       latch_mask;
    logic [31:0]       rise_mask;
    logic [31:0]       fall_mask;
    logic [31:0]       inv_prev;
    logic [31:0]       held;
    logic [31:0]       cond_prev;
    logic [31:0]       alarm;
    logic              limits_on;
    logic [31:0]       err_cnt;
    logic [31:0]       lim_cnt;
    logic [15:0]       lim_show;
    logic [31:0][15:0] lo_lim;
    logic [31:0][15:0] ceiling_threshold_key;
    logic [31:0][15:0] cal_val;
    logic [31:0][31:0] cal_ref;
    logic [31:0][1:0]  cal_mode;
    logic [31:0]       disp;
    logic              hi_al;
    logic              lo_al;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // ----------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------
  logic        wr_take;
  logic        rd_take;
  logic        key_fire;
  logic [3:0]  fn;
  logic        has_val;
  logic [15:0] val;

  // Address and data are taken together once the previous answer is gone.
  assign wr_take       = ce & s_axi_awvalid & s_axi_wvalid & ~st_reg.bvalid;
  assign rd_take       = ce & s_axi_arvalid & ~st_reg.rvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;
  assign key_fire      = wr_take & (s_axi_awaddr == OFS_KEY) & (s_axi_wstrb == 4'hf);
  assign fn            = s_axi_wdata[KEY_FN_LSB +: 4];
  assign has_val       = s_axi_wdata[KEY_HAS_BIT];
  assign val           = s_axi_wdata[KEY_VAL_LSB +: 16];

  // ----------------------------------------------------------------------
  // Levels of the selected channel and of the two channels before it
  // ----------------------------------------------------------------------
  logic [4:0]  idx;
  logic [4:0]  idx_p1;
  logic [4:0]  idx_p2;
  logic [15:0] lvl;
  logic [15:0] lvl_p1;
  logic [15:0] lvl_p2;

  assign idx    = 5'(st_reg.chan - 6'h01);
  assign idx_p1 = idx - 5'h01;
  assign idx_p2 = idx - 5'h02;
  assign lvl    = tele_levels[idx * LEVEL_W +: LEVEL_W];
  assign lvl_p1 = tele_levels[idx_p1 * LEVEL_W +: LEVEL_W];
  assign lvl_p2 = tele_levels[idx_p2 * LEVEL_W +: LEVEL_W];

  // ----------------------------------------------------------------------
  // Calibrated value of the selected channel
  // ----------------------------------------------------------------------
  logic [15:0] cval;
  logic [16:0] cabs;
  logic [31:0] num;
  logic [31:0] den;
  logic [48:0] quot;
  logic [31:0] scaled;

  // Magnitude times present measure, divided by the stored reference.
  always_comb
  begin
    cval = st_reg.cal_val[idx];
    cabs = cval[15] ? 17'(-$signed({cval[15], cval})) : {1'b0, cval};
    den  = st_reg.cal_ref[idx];
    unique case (st_reg.cal_mode[idx])
      CAL_LINEAR:  num = {16'h0000, lvl};
      CAL_SQUARE:  num = lvl * lvl;
      CAL_PRODUCT: num = lvl_p1 * lvl_p2;
      CAL_NONE:    num = {16'h0000, lvl};
    endcase
    quot = (den == 32'h0000_0000) ? 49'h0 : (cabs * num) / {17'h0, den};
    if (st_reg.cal_mode[idx] == CAL_NONE)
      scaled = {16'h0000, lvl};
    else if (st_reg.cal_mode[idx] == CAL_LINEAR && cval[15])
      scaled = 32'(-$signed(quot[31:0]));
    else
      scaled = quot[31:0];
  end

  // ----------------------------------------------------------------------
  // Status conditioning
  // ----------------------------------------------------------------------
  logic [31:0] inv_now;
  logic [31:0] release_all;
  logic [31:0] held_now;
  logic [31:0] cond_now;
  logic [31:0] cond_rise;
  logic [31:0] cond_fall;
  logic [31:0] alarm_clr;

  assign inv_now     = status_in ^ st_reg.inv_mask;
  assign release_all = (key_fire & fn == FN_RELEASE & ~has_val) ? '1 : '0;
  // A rising edge in the cycle of a release still latches the channel.
  assign held_now    = ((st_reg.held & ~release_all) | (inv_now & ~st_reg.inv_prev))
                       & st_reg.latch_mask;
  assign cond_now    = (st_reg.latch_mask & held_now) | (~st_reg.latch_mask & inv_now);
  assign cond_rise   = cond_now & ~st_reg.cond_prev;
  assign cond_fall   = ~cond_now & st_reg.cond_prev;
  assign alarm_clr   = (wr_take & s_axi_awaddr == OFS_ALARM)
                       ? (s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}})
                       : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic err;
    logic [31:0] sel_bit;
    logic [15:0] lim;
    err     = 1'b0;
    sel_bit = 32'h0000_0001 << idx;
    lim     = 16'h0000;
    st_next = st_reg;

    // Input conditioning and sticky edge alarms; a new edge beats a clear.
    st_next.inv_prev  = inv_now;
    st_next.held      = held_now;
    st_next.cond_prev = cond_now;
    st_next.alarm     = (st_reg.alarm & ~alarm_clr)
                        | (cond_rise & st_reg.rise_mask)
                        | (cond_fall & st_reg.fall_mask);

    // Display timers count down to zero.
    if (st_reg.err_cnt != 32'h0000_0000)
      st_next.err_cnt = st_reg.err_cnt - 32'h0000_0001;
    if (st_reg.lim_cnt != 32'h0000_0000)
      st_next.lim_cnt = st_reg.lim_cnt - 32'h0000_0001;

    // Function key acts in the cycle its word is taken.
    if (key_fire)
    begin
      unique case (fn)
        FN_LINE_PICK:
          if (!has_val)
            st_next.chan = (st_reg.chan == CHAN_LAST) ? CHAN_FIRST
                           : st_reg.chan + 6'h01;
          else if ($signed(val) >= 1 && $signed(val) <= 32)
            st_next.chan = val[5:0];
          else
            err = 1'b1;
        FN_SITE:
          if (has_val && val[15:8] == 8'h00)
            st_next.site = val[7:0];
          else
            err = 1'b1;
        FN_LATCH, FN_INVERT, FN_RISE_ALARM, FN_FALL_ALARM:
          if (has_val)
            err = 1'b1;
          else if (fn == FN_LATCH)
            st_next.latch_mask = st_reg.latch_mask ^ sel_bit;
          else if (fn == FN_INVERT)
            st_next.inv_mask = st_reg.inv_mask ^ sel_bit;
          else if (fn == FN_RISE_ALARM)
            st_next.rise_mask = st_reg.rise_mask ^ sel_bit;
          else
            st_next.fall_mask = st_reg.fall_mask ^ sel_bit;
        FN_RELEASE:
          err = has_val;
        FN_CAL_LINEAR:
          if (!has_val || lvl < MIN_CAL_MV)
            err = 1'b1;
          else
          begin
            st_next.cal_val[idx]  = val;
            st_next.cal_ref[idx]  = {16'h0000, lvl};
            st_next.cal_mode[idx] = CAL_LINEAR;
          end
        FN_CAL_SQUARE:
          if (!has_val)
            err = 1'b1;
          else if (!val[15])
          begin
            if (lvl < MIN_CAL_MV)
              err = 1'b1;
            else
            begin
              st_next.cal_val[idx]  = val;
              st_next.cal_ref[idx]  = lvl * lvl;
              st_next.cal_mode[idx] = CAL_SQUARE;
            end
          end
          else if (lvl_p1 < MIN_CAL_MV || lvl_p2 < MIN_CAL_MV)
            err = 1'b1;
          else
          begin
            st_next.cal_val[idx]  = val;
            st_next.cal_ref[idx]  = lvl_p1 * lvl_p2;
            st_next.cal_mode[idx] = CAL_PRODUCT;
          end
        FN_FLOOR, FN_CEILING:
        begin
          lim = (fn == FN_FLOOR) ? st_reg.lo_lim[idx] : st_reg.ceiling_threshold_key[idx];
          if (has_val && fn == FN_FLOOR)
            st_next.lo_lim[idx] = val;
          else if (has_val)
            st_next.ceiling_threshold_key[idx] = val;
          else
          begin
            st_next.lim_show = lim;
            st_next.lim_cnt  = 32'(HOLD_CYCLES);
          end
        end
        FN_THRESH_TGL:
          if (has_val)
            err = 1'b1;
          else
            st_next.limits_on = ~st_reg.limits_on;
        default:
          err = 1'b1;
      endcase
    end

    // Error indication restarts its two-second hold.
    if (err)
    begin
      st_next.err_cnt = 32'(HOLD_CYCLES);
      st_next.lim_cnt = 32'h0000_0000;
    end

    // Shown value and limit comparison; a zero limit never trips.
    st_next.disp  = (st_reg.lim_cnt != 32'h0000_0000)
                    ? {{16{st_reg.lim_show[15]}}, st_reg.lim_show} : scaled;
    st_next.hi_al = st_reg.limits_on && st_reg.ceiling_threshold_key[idx] != 16'h0000
                    && $signed(scaled) > $signed(st_reg.ceiling_threshold_key[idx]);
    st_next.lo_al = st_reg.limits_on && st_reg.lo_lim[idx] != 16'h0000
                    && $signed(scaled) < $signed(st_reg.lo_lim[idx]);

    // Write answer: OKAY for the key and alarm words, SLVERR elsewhere.
    if (wr_take)
    begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = (s_axi_awaddr == OFS_KEY || s_axi_awaddr == OFS_ALARM)
                       ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;

    // Read answer is registered one cycle after the address is taken.
    if (rd_take)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_KEY:     st_next.rdata = 32'h0000_0000;
        OFS_SELECT:  st_next.rdata = {16'h0000, st_reg.site, 2'h0, st_reg.chan};
        OFS_FLAGS:   st_next.rdata = {24'h0, st_reg.lo_al, st_reg.hi_al,
                                      (st_reg.err_cnt != 32'h0000_0000),
                                      st_reg.limits_on, attr_leds};
        OFS_STATUS:  st_next.rdata = st_reg.cond_prev;
        OFS_ALARM:   st_next.rdata = st_reg.alarm;
        OFS_DISPLAY: st_next.rdata = st_reg.disp;
        default:
        begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset stands for lost memory: the factory site number returns.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg      <= '0;
      st_reg.chan <= CHAN_FIRST;
      st_reg.site <= FACTORY_SITE;
    end
    else if (ce)
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign site_match    = (site_query == st_reg.site);
  assign chan_display  = st_reg.chan;
  assign status_leds   = st_reg.cond_prev;
  assign attr_leds     = {st_reg.fall_mask[idx], st_reg.rise_mask[idx],
                          st_reg.inv_mask[idx], st_reg.latch_mask[idx]};
  assign limits_led    = st_reg.limits_on;
  assign hi_alarm      = st_reg.hi_al;
  assign lo_alarm      = st_reg.lo_al;
  assign error_show    = (st_reg.err_cnt != 32'h0000_0000);
  assign display_value = st_reg.disp;

endmodule

// file: test/keypad_properties.sv
`timescale 1ns/1ps
module keypad_checker
#(
  parameter logic [7:0] FACTORY_SITE = 8'h01
)
(
  input wire logic                          aclk,
  input wire logic                          aresetn,
  input wire logic [keypad_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic [31:0]                   s_axi_wdata,
  input wire logic [3:0]                    s_axi_wstrb,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_bvalid,
  input wire logic [7:0]                    site_query,
  input wire logic                          site_match,
  input wire logic [5:0]                    chan_display,
  input wire logic [3:0]                    attr_leds,
  input wire logic                          limits_led,
  input wire logic                          error_show
);
  import keypad_pkg::*;
  logic               kw;
  logic [3:0]         fn;
  logic               has;
  logic signed [15:0] val;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Decode a whole key word taken by the bus.
  assign kw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
              && s_axi_awaddr == OFS_KEY && s_axi_wstrb == 4'hf;
  assign fn = s_axi_wdata[3:0];
  assign has = s_axi_wdata[8];
  assign val = s_axi_wdata[31:16];
  chk_key_resp: assert property (kw |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("Key write not answered OKAY.");
  chk_pick_val: assert property (kw && fn == FN_LINE_PICK && has && val >= 1 && val <= 32
    |=> chan_display == $past(val[5:0])) else $error("Picked channel not shown.");
  chk_pick_wrap: assert property (kw && fn == FN_LINE_PICK && !has && chan_display == CHAN_LAST
    |=> chan_display == CHAN_FIRST) else $error("Channel did not wrap.");
  chk_pick_step: assert property (kw && fn == FN_LINE_PICK && !has && chan_display != CHAN_LAST
    |=> chan_display == $past(chan_display) + 6'h01) else $error("Channel did not advance.");
  chk_pick_bad: assert property (kw && fn == FN_LINE_PICK && has && (val < 1 || val > 32)
    |=> $stable(chan_display) && error_show) else $error("Bad channel accepted.");
  chk_attr_reject: assert property (kw && has && fn >= FN_LATCH && fn <= FN_RELEASE
    |=> $stable(attr_leds) && error_show) else $error("Valued toggle accepted.");
  chk_threshold_check_toggle_toggle: assert property (kw && fn == FN_THRESH_TGL && !has
    |=> limits_led != $past(limits_led)) else $error("Limit enable did not toggle.");
  chk_site_reset: assert property ($past(!aresetn) && site_query == FACTORY_SITE
    |-> site_match) else $error("Factory site lost at reset.");
  chk_err_hold: assert property ($rose(error_show) |-> error_show [*8])
    else $error("Error indication too short.");
  cover property (kw && fn == FN_LINE_PICK && !has && chan_display == CHAN_LAST);
  cover property ($rose(error_show));
  cover property ($rose(limits_led));
endmodule

bind keypad_function_key_handler keypad_checker #(.FACTORY_SITE(FACTORY_SITE)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .site_query(site_query), .site_match(site_match),
  .chan_display(chan_display), .attr_leds(attr_leds), .limits_led(limits_led),
  .error_show(error_show));

// file: test/panel_model.sv
`timescale 1ns/1ps
// Field side: switch levels arrive one clock late, telemetry is steady per channel.
module panel_model
#(
  parameter logic [15:0] LOW_LEVEL  = 16'h0064,
  parameter logic [15:0] HIGH_LEVEL = 16'h0200
)
(
  input  wire logic                          aclk,
  input  wire logic [31:0]                   switches,
  output logic [31:0]                        status_in,
  output logic [keypad_pkg::NUM_CHAN*16-1:0] tele_levels
);
  // Register the switch levels like a real input stage.
  always_ff @(posedge aclk) status_in <= switches;
  // Channel 4 sits below the calibration floor, all others above it.
  always_comb
  begin
    for (int i = 0; i < 32; i++) tele_levels[16*i +: 16] = (i == 3) ? LOW_LEVEL : HIGH_LEVEL;
  end
endmodule

// file: test/keypad_function_key_handler_tb.sv
`timescale 1ns/1ps
module keypad_function_key_handler_tb;
  import keypad_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, arready, bvalid, rvalid;
  logic [7:0] awaddr, araddr, sq;
  logic [31:0] wdata, rdata, sw, st_in, status_leds, display_value;
  logic [1:0] bresp, rresp;
  logic [511:0] levels;
  logic [5:0] chan_display;
  logic [3:0] attr_leds;
  logic limits_led, hi_alarm, lo_alarm, error_show, site_match;
  int mismatches, cmp_count, cycles;
  keypad_function_key_handler #(.HOLD_CYCLES(20)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .status_in(st_in), .tele_levels(levels),
    .site_query(sq), .site_match(site_match), .chan_display(chan_display),
    .status_leds(status_leds),
    .attr_leds(attr_leds), .limits_led(limits_led), .hi_alarm(hi_alarm), .lo_alarm(lo_alarm),
    .error_show(error_show), .display_value(display_value));
  panel_model u_panel (.aclk(aclk), .switches(sw), .status_in(st_in), .tele_levels(levels));
  // Clock source and hang guard.
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic key(input logic [3:0] f, input logic h, input logic [15:0] v);
    wr(OFS_KEY, {v, 7'h00, h, 4'h0, f});
  endtask
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_SELECT, d, r);
    chk(d, 32'h0000_0101);
    rd(8'h3c, d, r);
    chk(r, RESP_SLVERR);
    sq <= 8'h08;
    key(FN_SITE, 1'b1, 16'h0008);
    chk(site_match, 32'h1);
  endtask
  task automatic t_select();
    key(FN_LINE_PICK, 1'b1, 16'h0020);
    chk(chan_display, 32'h20);
    key(FN_LINE_PICK, 1'b0, 16'h0000);
    chk(chan_display, 32'h01);
    key(FN_LINE_PICK, 1'b1, 16'h0028);
    chk({error_show, 2'h0, chan_display}, 32'h101);
    repeat (25) @(posedge aclk);
    chk(error_show, 32'h0);
  endtask
  task automatic t_status();
    logic [31:0] d;
    logic [1:0] r;
    key(FN_LINE_PICK, 1'b1, 16'h0001);
    key(FN_INVERT, 1'b0, 16'h0000);
    repeat (2) @(posedge aclk);
    chk({attr_leds, status_leds[0]}, 32'h05);
    key(FN_INVERT, 1'b0, 16'h0000);
    repeat (2) @(posedge aclk);
    chk({attr_leds, status_leds[0]}, 32'h00);
    key(FN_INVERT, 1'b1, 16'h0005);
    chk({error_show, attr_leds}, 32'h10);
    key(FN_LINE_PICK, 1'b1, 16'h0002);
    key(FN_LATCH, 1'b0, 16'h0000);
    key(FN_RISE_ALARM, 1'b0, 16'h0000);
    sw <= 32'h2;
    repeat (3) @(posedge aclk);
    sw <= 32'h0;
    repeat (3) @(posedge aclk);
    chk(status_leds[1], 32'h1);
    rd(OFS_ALARM, d, r);
    chk(d[1], 32'h1);
    wr(OFS_ALARM, 32'h2);
    key(FN_FALL_ALARM, 1'b0, 16'h0000);
    key(FN_RELEASE, 1'b0, 16'h0000);
    repeat (2) @(posedge aclk);
    chk(status_leds[1], 32'h0);
    rd(OFS_ALARM, d, r);
    chk(d, 32'h2);
  endtask
  task automatic t_cal();
    repeat (25) @(posedge aclk);
    key(FN_LINE_PICK, 1'b1, 16'h0004);
    key(FN_CAL_LINEAR, 1'b1, 16'd1000);
    chk(error_show, 32'h1);
    key(FN_LINE_PICK, 1'b1, 16'h0005);
    key(FN_CAL_LINEAR, 1'b1, 16'd1000);
    repeat (2) @(posedge aclk);
    chk(display_value, 32'd1000);
    key(FN_CAL_SQUARE, 1'b1, 16'd300);
    repeat (2) @(posedge aclk);
    chk(display_value, 32'd300);
  endtask
  task automatic t_limits();
    key(FN_CEILING, 1'b1, 16'd200);
    key(FN_THRESH_TGL, 1'b0, 16'h0000);
    repeat (2) @(posedge aclk);
    chk({limits_led, hi_alarm}, 32'h3);
    key(FN_CEILING, 1'b0, 16'h0000);
    repeat (2) @(posedge aclk);
    chk(display_value, 32'd200);
    key(FN_FLOOR, 1'b0, 16'h0000);
    repeat (2) @(posedge aclk);
    chk(display_value, 32'd0);
    key(FN_CEILING, 1'b1, 16'h0000);
    key(FN_FLOOR, 1'b1, 16'd400);
    repeat (2) @(posedge aclk);
    chk({hi_alarm, lo_alarm}, 32'h1);
    key(FN_THRESH_TGL, 1'b0, 16'h0000);
    chk(limits_led, 32'h0);
  endtask
  // Reset, then each scenario in turn.
  initial
  begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, sw} = '0;
    sq = 8'h01;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_bus();
    t_select();
    t_status();
    t_cal();
    t_limits();
    end_sim();
  end
endmodule
